/* core/cbls_defs.svh */
// Purpose: Constants for the branch and load/store execution block.
// Assumes: Included by the package and by every design file that needs it.
// Notes: Status bit positions, pointer bases and reset values live here.
//
// Functional notes
// - Signed ge branch taken when N xor V is zero; 1/2 cycles.
// - Signed less-than branch taken when N xor V is one; no flag change.
// - Non-negative branch taken only when N is zero; relative target.
// - Half-carry branches taken on H set or clear; 1/2 cycles.
// - Transfer-bit branches taken on T set or clear; no flag change.
// - Interrupt-enable branches taken on I set or clear; 1/2 cycles.
// - Taken branch loads PC plus signed offset plus one, else PC plus one.
// - Register copy moves source to destination in one cycle, no flags.
// - Post-increment load reads at pointer, then steps it; two cycles.
// - Pre-decrement load lowers pointer, reads at new address; two cycles.
// - Offset load reads at Y or Z plus displacement, pointer unchanged.
// - Absolute load reads embedded address into destination in two cycles.
// - Post-increment store writes at pointer, then pointer plus one.
// - Pre-decrement store lowers pointer, then writes at new address.
`ifndef CBLS_DEFS_SVH
`define CBLS_DEFS_SVH

// Status register bit positions.
`define CBLS_SR_I 7
`define CBLS_SR_T 6
`define CBLS_SR_H 5
`define CBLS_SR_V 3
`define CBLS_SR_N 2

// Low-byte register index of each pointer pair.
`define CBLS_PTR_X_BASE 5'h1a
`define CBLS_PTR_Y_BASE 5'h1c
`define CBLS_PTR_Z_BASE 5'h1e

// Reset values.
`define CBLS_PC_RST 16'h0000
`define CBLS_REG_RST 8'h00

// Register file shape and read port roles.
`define CBLS_NREG 32
`define CBLS_NRD 4
`define CBLS_RP_SRC 0
`define CBLS_RP_PLO 1
`define CBLS_RP_PHI 2
`define CBLS_RP_DBG 3

`endif

/* core/cbls_exec.sv */
// Purpose: Executes conditional branches, register copy, loads and stores.
// Assumes: Decoder, status register and data memory share clk.
// Notes: Memory reads return data in the cycle the read strobe is high.
`timescale 1ns/1ps
`default_nettype none
`include "cbls_defs.svh"

module cbls_exec (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Decoded instruction handshake.
  input wire logic req_valid,
  input wire cbls_pkg::cbls_req_s req,
  output logic req_ready,
  // Status register snapshot from the core.
  input wire logic [7:0] status_register,
  // Program counter.
  output logic [15:0] pc,
  // Data memory port.
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [7:0] mem_rdata,
  // Register observation port.
  input wire logic [4:0] dbg_addr,
  output logic [7:0] dbg_data
);

  cbls_pkg::cbls_state_e state_ff;
  cbls_pkg::cbls_state_e nxt_state;
  cbls_pkg::cbls_req_s cur_ff;
  cbls_pkg::cbls_req_s nxt_cur;
  logic [15:0] pc_ff;
  logic [15:0] nxt_pc;
  logic ready_ff;
  logic nxt_ready;
  logic [15:0] mem_addr_ff;
  logic [15:0] nxt_mem_addr;
  logic [7:0] mem_wdata_ff;
  logic [7:0] nxt_mem_wdata;
  logic mem_we_ff;
  logic nxt_mem_we;
  logic mem_re_ff;
  logic nxt_mem_re;
  logic [4:0] ld_rd_ff;
  logic [4:0] nxt_ld_rd;
  logic copy_pend_ff;
  logic nxt_copy_pend;
  logic [4:0] copy_rd_ff;
  logic [4:0] nxt_copy_rd;

  logic fire;
  logic taken;
  logic [4:0] req_base;
  logic [4:0] cur_base;
  logic [15:0] ptr_val;
  logic [15:0] ptr_step;
  logic [15:0] eff_addr;
  logic [`CBLS_NRD-1:0][4:0] rf_raddr;
  logic [`CBLS_NRD-1:0][7:0] rf_rdata;
  logic wa_en;
  logic [4:0] wa_addr;
  logic [7:0] wa_data;
  logic wb_en;

  assign fire = req_valid && ready_ff;

  // Low-byte index of the pointer pair for the incoming and held request.
  always_comb begin
    unique case (req.ptr)
      cbls_pkg::CBLS_PTR_Y: req_base = `CBLS_PTR_Y_BASE;
      cbls_pkg::CBLS_PTR_Z: req_base = `CBLS_PTR_Z_BASE;
      default: req_base = `CBLS_PTR_X_BASE;
    endcase
    unique case (cur_ff.ptr)
      cbls_pkg::CBLS_PTR_Y: cur_base = `CBLS_PTR_Y_BASE;
      cbls_pkg::CBLS_PTR_Z: cur_base = `CBLS_PTR_Z_BASE;
      default: cur_base = `CBLS_PTR_X_BASE;
    endcase
  end

  // Branch condition from the status register; flags are only read.
  always_comb begin
    unique case (req.op)
      cbls_pkg::CBLS_BRANCH_SIGNED_GE:
        taken = ~(status_register[`CBLS_SR_N] ^ status_register[`CBLS_SR_V]);
      cbls_pkg::CBLS_BRANCH_SIGNED_LT:
        taken = status_register[`CBLS_SR_N] ^ status_register[`CBLS_SR_V];
      cbls_pkg::CBLS_BRANCH_NON_NEGATIVE:
        taken = ~status_register[`CBLS_SR_N];
      cbls_pkg::CBLS_BRANCH_HALF_CARRY_SET:
        taken = status_register[`CBLS_SR_H];
      cbls_pkg::CBLS_BRANCH_HALF_CARRY_CLEAR:
        taken = ~status_register[`CBLS_SR_H];
      cbls_pkg::CBLS_BRANCH_TRANSFER_BIT_SET:
        taken = status_register[`CBLS_SR_T];
      cbls_pkg::CBLS_BRANCH_TRANSFER_BIT_CLEAR:
        taken = ~status_register[`CBLS_SR_T];
      cbls_pkg::CBLS_BRANCH_IRQ_ENABLED:
        taken = status_register[`CBLS_SR_I];
      cbls_pkg::CBLS_BRANCH_IRQ_DISABLED:
        taken = ~status_register[`CBLS_SR_I];
      default: taken = 1'b0;
    endcase
  end

  // Pointer value and effective address for the held request.
  always_comb begin
    ptr_val = {rf_rdata[`CBLS_RP_PHI], rf_rdata[`CBLS_RP_PLO]};
    if (cur_ff.mode == cbls_pkg::CBLS_AM_PRE_DEC) begin
      ptr_step = ptr_val - 16'h0001;
    end else begin
      ptr_step = ptr_val + 16'h0001;
    end
    if (cur_ff.op == cbls_pkg::CBLS_OFFSET_LOAD) begin
      eff_addr = ptr_val + {10'h000, cur_ff.disp};
    end else if (cur_ff.mode == cbls_pkg::CBLS_AM_PRE_DEC) begin
      eff_addr = ptr_step;
    end else begin
      eff_addr = ptr_val;
    end
  end

  // Register file read addresses are taken from the incoming request, except the debug port, which uses dbg_addr.
  always_comb begin
    rf_raddr[`CBLS_RP_SRC] = req.rr;
    rf_raddr[`CBLS_RP_PLO] = req_base;
    rf_raddr[`CBLS_RP_PHI] = req_base | 5'h01;
    rf_raddr[`CBLS_RP_DBG] = dbg_addr;
  end

  // Byte and pair write requests into the register file.
  always_comb begin
    wa_en = 1'b0;
    wa_addr = copy_rd_ff;
    wa_data = rf_rdata[`CBLS_RP_SRC];
    if (mem_re_ff) begin
      wa_en = 1'b1;
      wa_addr = ld_rd_ff;
      wa_data = mem_rdata;
    end else if (copy_pend_ff) begin
      wa_en = 1'b1;
    end
    wb_en = (state_ff == cbls_pkg::CBLS_ST_ADDR) &&
            (cur_ff.op != cbls_pkg::CBLS_OFFSET_LOAD) &&
            (cur_ff.mode != cbls_pkg::CBLS_AM_PLAIN);
  end

  // Sequencing of each instruction.
  always_comb begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_pc = pc_ff;
    nxt_mem_addr = mem_addr_ff;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_mem_we = 1'b0;
    nxt_mem_re = 1'b0;
    nxt_ld_rd = ld_rd_ff;
    nxt_copy_pend = 1'b0;
    nxt_copy_rd = copy_rd_ff;
    unique case (state_ff)
      cbls_pkg::CBLS_ST_IDLE: begin
        if (fire) begin
          nxt_pc = pc_ff + 16'h0001;
          unique case (req.op)
            cbls_pkg::CBLS_REG_COPY: begin
              nxt_copy_pend = 1'b1;
              nxt_copy_rd = req.rd;
            end
            cbls_pkg::CBLS_ABSOLUTE_LOAD: begin
              nxt_mem_addr = req.addr;
              nxt_mem_re = 1'b1;
              nxt_ld_rd = req.rd;
              nxt_state = cbls_pkg::CBLS_ST_WAIT;
            end
            cbls_pkg::CBLS_INDIRECT_LOAD, cbls_pkg::CBLS_OFFSET_LOAD,
            cbls_pkg::CBLS_INDIRECT_STORE: begin
              nxt_cur = req;
              nxt_state = cbls_pkg::CBLS_ST_ADDR;
            end
            default: begin
              if (taken) begin
                nxt_pc = pc_ff + {{9{req.offset[6]}}, req.offset} + 16'h0001;
                nxt_state = cbls_pkg::CBLS_ST_WAIT;
              end
            end
          endcase
        end
      end
      cbls_pkg::CBLS_ST_ADDR: begin
        nxt_mem_addr = eff_addr;
        if (cur_ff.op == cbls_pkg::CBLS_INDIRECT_STORE) begin
          nxt_mem_we = 1'b1;
          nxt_mem_wdata = rf_rdata[`CBLS_RP_SRC];
        end else begin
          nxt_mem_re = 1'b1;
          nxt_ld_rd = cur_ff.rd;
        end
        nxt_state = cbls_pkg::CBLS_ST_IDLE;
      end
      cbls_pkg::CBLS_ST_WAIT: begin
        nxt_state = cbls_pkg::CBLS_ST_IDLE;
      end
      default: begin
        nxt_state = cbls_pkg::CBLS_ST_IDLE;
      end
    endcase
    nxt_ready = (nxt_state == cbls_pkg::CBLS_ST_IDLE);
  end

  // Control and output registers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= cbls_pkg::CBLS_ST_IDLE;
      cur_ff <= '0;
      pc_ff <= `CBLS_PC_RST;
      ready_ff <= 1'b0;
      mem_addr_ff <= 16'h0000;
      mem_wdata_ff <= 8'h00;
      mem_we_ff <= 1'b0;
      mem_re_ff <= 1'b0;
      ld_rd_ff <= 5'h00;
      copy_pend_ff <= 1'b0;
      copy_rd_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      cur_ff <= nxt_cur;
      pc_ff <= nxt_pc;
      ready_ff <= nxt_ready;
      mem_addr_ff <= nxt_mem_addr;
      mem_wdata_ff <= nxt_mem_wdata;
      mem_we_ff <= nxt_mem_we;
      mem_re_ff <= nxt_mem_re;
      ld_rd_ff <= nxt_ld_rd;
      copy_pend_ff <= nxt_copy_pend;
      copy_rd_ff <= nxt_copy_rd;
    end
  end

  // Working registers, including the three pointer pairs.
  cbls_regfile u_rf (
    .clk(clk),
    .sys_rst(sys_rst),
    .raddr(rf_raddr),
    .rdata(rf_rdata),
    .wa_en(wa_en),
    .wa_addr(wa_addr),
    .wa_data(wa_data),
    .wb_en(wb_en),
    .wb_addr(cur_base),
    .wb_data(ptr_step)
  );

  assign req_ready = ready_ff;
  assign pc = pc_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign mem_we = mem_we_ff;
  assign mem_re = mem_re_ff;
  assign dbg_data = rf_rdata[`CBLS_RP_DBG];

endmodule : cbls_exec

`default_nettype wire

/* core/cbls_pkg.sv */
// Purpose: Types shared by the branch and load/store execution block.
// Assumes: Constants come from the defs header.
// Notes: The decoder hands one cbls_req_s per instruction.
`include "cbls_defs.svh"

package cbls_pkg;

  // Decoded operation.
  typedef enum logic [3:0] {
    CBLS_NOP = 4'h0,
    CBLS_BRANCH_SIGNED_GE = 4'h1,
    CBLS_BRANCH_SIGNED_LT = 4'h2,
    CBLS_BRANCH_NON_NEGATIVE = 4'h3,
    CBLS_BRANCH_HALF_CARRY_SET = 4'h4,
    CBLS_BRANCH_HALF_CARRY_CLEAR = 4'h5,
    CBLS_BRANCH_TRANSFER_BIT_SET = 4'h6,
    CBLS_BRANCH_TRANSFER_BIT_CLEAR = 4'h7,
    CBLS_BRANCH_IRQ_ENABLED = 4'h8,
    CBLS_BRANCH_IRQ_DISABLED = 4'h9,
    CBLS_REG_COPY = 4'ha,
    CBLS_INDIRECT_LOAD = 4'hb,
    CBLS_OFFSET_LOAD = 4'hc,
    CBLS_ABSOLUTE_LOAD = 4'hd,
    CBLS_INDIRECT_STORE = 4'he
  } cbls_op_e;

  // Pointer addressing mode.
  typedef enum logic [1:0] {
    CBLS_AM_PLAIN = 2'h0,
    CBLS_AM_POST_INC = 2'h1,
    CBLS_AM_PRE_DEC = 2'h2
  } cbls_am_e;

  // Pointer pair select.
  typedef enum logic [1:0] {
    CBLS_PTR_X = 2'h0,
    CBLS_PTR_Y = 2'h1,
    CBLS_PTR_Z = 2'h2
  } cbls_ptr_e;

  // One decoded instruction.
  typedef struct packed {
    cbls_op_e op;
    cbls_am_e mode;
    cbls_ptr_e ptr;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [5:0] disp;
    logic [6:0] offset;
    logic [15:0] addr;
  } cbls_req_s;

  // Control states, one-hot.
  typedef enum logic [2:0] {
    CBLS_ST_IDLE = 3'b001,
    CBLS_ST_ADDR = 3'b010,
    CBLS_ST_WAIT = 3'b100
  } cbls_state_e;

endpackage : cbls_pkg

/* core/cbls_regfile.sv */
// Purpose: 32 x 8 working register file with registered read ports.
// Assumes: One byte write port and one pair write port on the same clock.
// Notes: A read in the cycle of a write to the same entry sees the new data.
`timescale 1ns/1ps
`default_nettype none
`include "cbls_defs.svh"

module cbls_regfile (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Read ports.
  input wire logic [`CBLS_NRD-1:0][4:0] raddr,
  output logic [`CBLS_NRD-1:0][7:0] rdata,
  // Byte write port, wins over the pair port.
  input wire logic wa_en,
  input wire logic [4:0] wa_addr,
  input wire logic [7:0] wa_data,
  // Pair write port, even index addresses the low byte.
  input wire logic wb_en,
  input wire logic [4:0] wb_addr,
  input wire logic [15:0] wb_data
);

  logic [`CBLS_NREG-1:0][7:0] mem_ff;
  logic [`CBLS_NREG-1:0][7:0] nxt_mem;
  logic [`CBLS_NRD-1:0][7:0] rdata_ff;
  logic [`CBLS_NRD-1:0][7:0] nxt_rdata;

  genvar gi;
  generate
    for (gi = 0; gi < `CBLS_NREG; gi = gi + 1) begin : g_ent
      // Next value of each entry from the two write ports.
      always_comb begin
        nxt_mem[gi] = mem_ff[gi];
        if (wa_en && (wa_addr == 5'(gi))) begin
          nxt_mem[gi] = wa_data;
        end else if (wb_en && (wb_addr == 5'(gi & 30))) begin
          nxt_mem[gi] = (gi % 2 == 1) ? wb_data[15:8] : wb_data[7:0];
        end
      end

      // Entry storage.
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          mem_ff[gi] <= `CBLS_REG_RST;
        end else begin
          mem_ff[gi] <= nxt_mem[gi];
        end
      end
    end

    for (gi = 0; gi < `CBLS_NRD; gi = gi + 1) begin : g_rd
      // Read with write-through so a same-cycle write is not missed.
      always_comb begin
        nxt_rdata[gi] = nxt_mem[raddr[gi]];
      end

      // Registered read data.
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          rdata_ff[gi] <= `CBLS_REG_RST;
        end else begin
          rdata_ff[gi] <= nxt_rdata[gi];
        end
      end
    end
  endgenerate

  assign rdata = rdata_ff;

endmodule : cbls_regfile

`default_nettype wire

/* sim/cbls_exec_bench.sv */
// Purpose: Self-checking bench for cbls_exec against a behavioural model.
// Assumes: Memory reads are combinational; one 40 MHz clock.
// Notes: Registers are seen through the observation port only.
`timescale 1ns/1ps
`default_nettype none
`include "cbls_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module cbls_exec_bench;
  logic clk, sys_rst, req_valid, req_ready, mem_we, mem_re;
  logic [7:0] status_register, mem_wdata, mem_rdata, dbg_data;
  logic [15:0] pc, mem_addr;
  logic [4:0] dbg_addr;
  logic [31:0] rs;
  logic [7:0] mem [256];
  logic [23:0] wq [$];
  logic [23:0] ew;
  logic [15:0] rq [$];
  logic [15:0] er;
  int regs [32];
  int mpc, err_total, tests_run;
  cbls_pkg::cbls_req_s req;

  cbls_exec u_cbls_exec (.clk(clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .status_register(status_register), .pc(pc), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
    .mem_rdata(mem_rdata), .dbg_addr(dbg_addr), .dbg_data(dbg_data));

  // Memory answers at once from the low address byte.
  assign mem_rdata = mem[mem_addr[7:0]];

  // Clock of 25 ns.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Each write and each read matches the next expected access in order.
  always @(posedge clk) begin
    if (mem_we === 1'b1) begin
      ew = (wq.size() > 0) ? wq.pop_front() : 24'hxxxxxx;
      `CHK({mem_addr, mem_wdata}, ew)
      mem[mem_addr[7:0]] <= mem_wdata;
    end
    if (mem_re === 1'b1) begin
      er = (rq.size() > 0) ? rq.pop_front() : 16'hxxxx;
      `CHK(mem_addr, er)
    end
  end

  // Xorshift source of all random stimulus.
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  // Random request; the offset load only uses the second or third pointer.
  function automatic cbls_pkg::cbls_req_s mk(input logic [3:0] op);
    cbls_pkg::cbls_req_s r;
    logic [31:0] x;
    logic [31:0] y;
    x = rnd();
    y = rnd();
    r.op = cbls_pkg::cbls_op_e'(op);
    r.mode = cbls_pkg::cbls_am_e'(2'(y % 3));
    r.ptr = cbls_pkg::cbls_ptr_e'(2'(x[31:24] % 3));
    if (r.op == cbls_pkg::CBLS_OFFSET_LOAD)
      r.ptr = cbls_pkg::cbls_ptr_e'({1'b0, y[8]} + 2'h1);
    {r.rd, r.rr, r.disp, r.offset} = x[22:0];
    r.addr = y[31:16];
    return r;
  endfunction : mk

  task automatic test_done();
    $display("Checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // Hold a request until taken, then step the model and compare.
  task automatic issue(input cbls_pkg::cbls_req_s r, input logic [7:0] sr);
    int k, b, p, a, d;
    logic rdy, c, n, xv, st;
    req = r;
    status_register = sr;
    req_valid = 1'b1;
    k = 0;
    while (req_ready !== 1'b1 && k < 20) begin
      @(posedge clk);
      #2;
      k++;
    end
    if (req_ready !== 1'b1) begin
      err_total++;
      test_done();
    end
    @(posedge clk);
    #2;
    b = `CBLS_PTR_X_BASE + 2 * r.ptr;
    p = regs[b] + 256 * regs[b + 1];
    d = regs[r.rr];
    n = sr[`CBLS_SR_N];
    xv = n ^ sr[`CBLS_SR_V];
    st = r.op == cbls_pkg::CBLS_INDIRECT_STORE;
    mpc = (mpc + 1) % 65536;
    rdy = r.op < cbls_pkg::CBLS_INDIRECT_LOAD;
    c = 1'b0;
    case (r.op)
      cbls_pkg::CBLS_BRANCH_SIGNED_GE: c = !xv;
      cbls_pkg::CBLS_BRANCH_SIGNED_LT: c = xv;
      cbls_pkg::CBLS_BRANCH_NON_NEGATIVE: c = !n;
      cbls_pkg::CBLS_BRANCH_HALF_CARRY_SET: c = sr[`CBLS_SR_H];
      cbls_pkg::CBLS_BRANCH_HALF_CARRY_CLEAR: c = !sr[`CBLS_SR_H];
      cbls_pkg::CBLS_BRANCH_TRANSFER_BIT_SET: c = sr[`CBLS_SR_T];
      cbls_pkg::CBLS_BRANCH_TRANSFER_BIT_CLEAR: c = !sr[`CBLS_SR_T];
      cbls_pkg::CBLS_BRANCH_IRQ_ENABLED: c = sr[`CBLS_SR_I];
      cbls_pkg::CBLS_BRANCH_IRQ_DISABLED: c = !sr[`CBLS_SR_I];
      cbls_pkg::CBLS_REG_COPY: regs[r.rd] = d;
      cbls_pkg::CBLS_ABSOLUTE_LOAD: regs[r.rd] = mem[r.addr[7:0]];
      cbls_pkg::CBLS_OFFSET_LOAD: regs[r.rd] = mem[(p + r.disp) % 256];
      cbls_pkg::CBLS_INDIRECT_LOAD, cbls_pkg::CBLS_INDIRECT_STORE: begin
        if (r.mode == cbls_pkg::CBLS_AM_PRE_DEC) p = (p + 65535) % 65536;
        a = p;
        if (r.mode == cbls_pkg::CBLS_AM_POST_INC) p = (p + 1) % 65536;
        regs[b] = p % 256;
        regs[b + 1] = p / 256;
        if (st) begin
          wq.push_back({a[15:0], d[7:0]});
        end else begin
          regs[r.rd] = mem[a % 256];
          rq.push_back(a[15:0]);
        end
      end
      default: c = 1'b0;
    endcase
    // Expected read addresses of the direct and offset loads.
    if (r.op == cbls_pkg::CBLS_ABSOLUTE_LOAD) rq.push_back(r.addr);
    if (r.op == cbls_pkg::CBLS_OFFSET_LOAD) rq.push_back(16'(p + r.disp));
    if (c) begin
      rdy = 1'b0;
      mpc = (mpc + {{9{r.offset[6]}}, r.offset}) % 65536;
    end
    `CHK(req_ready, rdy)
    `CHK(pc, mpc[15:0])
  endtask : issue

  // Drop the request, let an edge pass, then read back every register.
  task automatic settle();
    req_valid = 1'b0;
    @(posedge clk);
    #2;
    for (int i = 0; i < 32; i++) begin
      dbg_addr = i[4:0];
      @(posedge clk);
      #2;
      `CHK(dbg_data, regs[i][7:0])
    end
  endtask : settle

  // Reset, preload, pointer wrap, every branch, then a random mix.
  initial begin
    cbls_pkg::cbls_req_s r;
    logic [7:0] sr;
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    status_register = 8'h00;
    dbg_addr = 5'h00;
    rs = 32'h0000000c;
    err_total = 0;
    tests_run = 0;
    mpc = 0;
    foreach (regs[i]) regs[i] = 0;
    foreach (mem[i]) mem[i] = 8'(rnd());
    mem[0] = 8'hff;
    repeat (8) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    @(posedge clk);
    #2;
    for (int i = 0; i < 33; i++) begin
      r = mk(4'hd);
      r.rd = i[4:0];
      if (i == 32) r.addr = 16'h0000;
      if (i == 32) r.rd = 5'h1a;
      issue(r, 8'(rnd()));
    end
    // first pointer steps across the top of memory both ways.
    r.rd = 5'h1b;
    issue(r, 8'h00);
    r.op = cbls_pkg::CBLS_INDIRECT_LOAD;
    r.ptr = cbls_pkg::CBLS_PTR_X;
    r.mode = cbls_pkg::CBLS_AM_POST_INC;
    r.rd = 5'h01;
    issue(r, 8'h00);
    r.op = cbls_pkg::CBLS_INDIRECT_STORE;
    r.mode = cbls_pkg::CBLS_AM_PRE_DEC;
    issue(r, 8'h00);
    settle();
    for (int o = 0; o < 10; o++) begin
      for (int j = 0; j < 4; j++) begin
        r = mk(o[3:0]);
        r.offset = j[1] ? 7'h40 : 7'h3f;
        sr = 8'(rnd()) & 8'h13;
        sr = sr | (j[0] ? 8'he4 : 8'h00) | (j[1] ? 8'h08 : 8'h00);
        issue(r, sr);
      end
    end
    for (int i = 0; i < 400; i++) issue(mk(4'(rnd() % 15)), 8'(rnd()));
    settle();
    `CHK(wq.size(), 0)
    `CHK(rq.size(), 0)
    test_done();
  end

endmodule : cbls_exec_bench

`default_nettype wire

/* sim/cbls_exec_checker.sv */
// Purpose: Port timing checks for the branch and load/store block.
// Assumes: One clock; sys_rst is asynchronous and active high.
// Notes: Register contents are judged by the bench model.
`timescale 1ns/1ps
`default_nettype none

module cbls_exec_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Request side.
  input wire logic req_valid,
  input wire cbls_pkg::cbls_req_s req,
  input wire logic req_ready,
  // Results.
  input wire logic [15:0] pc,
  input wire logic [15:0] mem_addr,
  input wire logic mem_we,
  input wire logic mem_re
);
  logic acc;
  logic is_br;
  logic [15:0] soff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Accept strobe, branch class and sign-extended offset.
  assign acc = req_valid && req_ready;
  assign is_br = req.op != cbls_pkg::CBLS_NOP &&
    req.op <= cbls_pkg::CBLS_BRANCH_IRQ_DISABLED;
  assign soff = {{9{req.offset[6]}}, req.offset};

  // Two-cycle memory step: stalled first, then strobe with ready.
  sequence s_two(strb);
    !req_ready && !strb ##1 req_ready && strb;
  endsequence

  a_br_target:
    assert property (acc && is_br |=>
      (req_ready && pc == $past(pc) + 16'h0001) or
      (!req_ready && pc == $past(pc) + $past(soff) + 16'h0001 ##1 req_ready))
      else $error("branch target or cost wrong");
  a_br_no_mem:
    assert property (acc && is_br |=> !mem_we && !mem_re)
      else $error("branch drove a memory strobe");
  a_copy_one:
    assert property (acc && req.op == cbls_pkg::CBLS_REG_COPY |=>
      req_ready && !mem_we && !mem_re && pc == $past(pc) + 16'h0001)
      else $error("copy cost wrong");
  a_abs_load:
    assert property (acc && req.op == cbls_pkg::CBLS_ABSOLUTE_LOAD |=>
      mem_re && !req_ready && mem_addr == $past(req.addr) ##1 req_ready)
      else $error("absolute load timing wrong");
  a_ind_load:
    assert property (acc && req.op == cbls_pkg::CBLS_INDIRECT_LOAD |=>
      s_two(mem_re))
      else $error("indirect load timing wrong");
  a_off_load:
    assert property (acc && req.op == cbls_pkg::CBLS_OFFSET_LOAD |=>
      s_two(mem_re))
      else $error("offset load timing wrong");
  a_store_seq:
    assert property (acc && req.op == cbls_pkg::CBLS_INDIRECT_STORE |=>
      s_two(mem_we))
      else $error("store timing wrong");
  a_pc_hold:
    assert property (!acc |=> pc == $past(pc))
      else $error("pc moved without a request");

endmodule : cbls_exec_checker

bind cbls_exec cbls_exec_checker u_chk (.clk(clk), .sys_rst(sys_rst),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .pc(pc),
  .mem_addr(mem_addr), .mem_we(mem_we), .mem_re(mem_re));

`default_nettype wire
